// [design/ics_defs.svh]
// Constants for the channel switch control link
`ifndef ICS_DEFS_SVH
`define ICS_DEFS_SVH
`define ICS_ADDR_UPPER      4'hE
`define ICS_SEL_RESET       8'h00
`define ICS_GLITCH_CYCLES   4'h4
`define ICS_RST_WIDTH_NS    6
`define ICS_RST_RELEASE_NS  500
`define ICS_CLK_NS          4
`define ICS_RST_MIN_CYC     ((`ICS_RST_WIDTH_NS + `ICS_CLK_NS - 1) / `ICS_CLK_NS)
`define ICS_RST_REL_CYC     (`ICS_RST_RELEASE_NS / `ICS_CLK_NS)
`define ICS_HALF_BIT        8'h40
`define ICS_QUARTER_BIT     8'h20
`define ICS_REG_CTRL        2'h0
`define ICS_REG_STATUS      2'h1
`define ICS_REG_WDATA       2'h2
`define ICS_REG_RDATA       2'h3
`define ICS_CMD_GO          0
`define ICS_CMD_READ        1
`endif

// [design/ics_pkg.sv]
// Types shared by both ends of the channel switch control link
package ics_pkg;
    typedef enum logic [2:0] {
        ICS_D_IDLE = 3'h0,
        ICS_D_ADDR = 3'h1,
        ICS_D_AACK = 3'h2,
        ICS_D_WR   = 3'h3,
        ICS_D_WACK = 3'h4,
        ICS_D_RD   = 3'h5,
        ICS_D_RACK = 3'h6,
        ICS_D_SKIP = 3'h7
    } ics_dev_state_t;

    typedef enum logic [3:0] {
        ICS_H_IDLE  = 4'h0,
        ICS_H_START = 4'h1,
        ICS_H_LOW   = 4'h2,
        ICS_H_HIGH  = 4'h3,
        ICS_H_STOP0 = 4'h4,
        ICS_H_STOP1 = 4'h5,
        ICS_H_STOP2 = 4'h6,
        ICS_H_DONE  = 4'h7
    } ics_host_state_t;
endpackage

// [design/ics_link_if.sv]
// Two-wire upstream link between host master and switch device
`timescale 1ns/10ps
interface ics_link_if;
    logic scl_o;
    logic scl_oe;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic scl;
    logic sda;

    // Open drain with pull-ups
    assign scl = ~(scl_oe & ~scl_o);
    assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

    modport host (
        output scl_o,
        output scl_oe,
        output sda_host_o,
        output sda_host_oe,
        input  scl,
        input  sda
    );
    modport dev (
        output sda_dev_o,
        output sda_dev_oe,
        input  scl,
        input  sda
    );
endinterface

// [design/ics_device.sv]
// Channel switch device: serial target, select register, channel enables
// Summary of operation
// - Answer address 0x70-0x77 from strap pins
// - Last address bit: 1 read, 0 write
// - Acknowledge matching address with data low
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Address shifted MSB first, direction last
// - One bit per clock, stable while high
// - Acknowledge bit after every eight bits
// - Acknowledge every byte written to device
// - Master NACK ends read; device releases
// - Eight-bit select, one bit per channel
// - Write stores select; read returns it
// - New selection connects only after stop
// - Multiple bytes: last one kept
// - Master stops right after control byte
// - Reset input clears registers and channels
// - Power-on reset starts in default state
// - Straps stable between start and stop
// - Master starts only when bus idle
// - Select resets to all zeros
// - Reset input held low six ns
// - Data released within 500 ns of reset
`timescale 1ns/10ps
`include "ics_defs.svh"
module ics_device (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       rst_in_n,
    input  wire logic [2:0] addr_strap,
    ics_link_if.dev         link,
    output logic [7:0]      chan_en,
    output logic [7:0]      sel_pending
);
    typedef struct packed {
        logic [1:0]              scl_sy;
        logic [1:0]              sda_sy;
        logic [1:0]              rst_sy;
        logic [2:0]              strap_s1;
        logic [2:0]              strap_s2;
        logic [3:0]              scl_cnt;
        logic [3:0]              sda_cnt;
        logic                    scl_f;
        logic                    sda_f;
        ics_pkg::ics_dev_state_t st;
        logic [3:0]              bitn;
        logic [7:0]              shreg;
        logic [7:0]              sel;
        logic [7:0]              en;
        logic                    sda_low;
    } ics_dev_reg_t;

    ics_dev_reg_t r_q;
    ics_dev_reg_t r_d;
    logic         scl_rise;
    logic         scl_fall;
    logic         start_c;
    logic         stop_c;

    always_comb begin
        r_d = r_q;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_c = 1'b0;
        stop_c = 1'b0;
        // Two-flop sync on pins
        r_d.scl_sy = {r_q.scl_sy[0], link.scl};
        r_d.sda_sy = {r_q.sda_sy[0], link.sda};
        r_d.rst_sy = {r_q.rst_sy[0], rst_in_n};
        r_d.strap_s1 = addr_strap;
        r_d.strap_s2 = r_q.strap_s1;

        // Edges act on filtered levels, so a short spike never moves a bit
        // Accept a level only after it holds several cycles
        if (r_q.scl_sy[1] == r_q.scl_f) begin
            r_d.scl_cnt = 4'h0;
        end else if (r_q.scl_cnt == `ICS_GLITCH_CYCLES) begin
            r_d.scl_f = r_q.scl_sy[1];
            r_d.scl_cnt = 4'h0;
            scl_rise = r_q.scl_sy[1];
            scl_fall = ~r_q.scl_sy[1];
        end else begin
            r_d.scl_cnt = r_q.scl_cnt + 4'h1;
        end
        if (r_q.sda_sy[1] == r_q.sda_f) begin
            r_d.sda_cnt = 4'h0;
        end else if (r_q.sda_cnt == `ICS_GLITCH_CYCLES) begin
            r_d.sda_f = r_q.sda_sy[1];
            r_d.sda_cnt = 4'h0;
            start_c = r_q.scl_f & r_q.sda_f;
            stop_c = r_q.scl_f & ~r_q.sda_f;
        end else begin
            r_d.sda_cnt = r_q.sda_cnt + 4'h1;
        end

        if (start_c) begin
            r_d.st = ics_pkg::ICS_D_ADDR;
            r_d.bitn = 4'h0;
            r_d.sda_low = 1'b0;
        end else if (stop_c) begin
            r_d.st = ics_pkg::ICS_D_IDLE;
            r_d.bitn = 4'h0;
            r_d.sda_low = 1'b0;
            r_d.en = r_q.sel;
        end else begin
            case (r_q.st)
                ics_pkg::ICS_D_ADDR, ics_pkg::ICS_D_WR: begin
                    if (scl_rise) begin
                        // MSB first, one bit per pulse
                        r_d.shreg = {r_q.shreg[6:0], r_q.sda_f};
                        r_d.bitn = r_q.bitn + 4'h1;
                    end
                    if (scl_fall && r_q.bitn == 4'h8) begin
                        r_d.bitn = 4'h0;
                        if (r_q.st == ics_pkg::ICS_D_WR) begin
                            r_d.sel = r_q.shreg;
                            r_d.sda_low = 1'b1;
                            r_d.st = ics_pkg::ICS_D_WACK;
                        end else if (r_q.shreg[7:1] ==
                                     {`ICS_ADDR_UPPER, r_q.strap_s2}) begin
                            r_d.sda_low = 1'b1;
                            r_d.st = ics_pkg::ICS_D_AACK;
                        end else begin
                            r_d.st = ics_pkg::ICS_D_SKIP;
                        end
                    end
                end
                ics_pkg::ICS_D_AACK, ics_pkg::ICS_D_WACK: begin
                    if (scl_fall) begin
                        r_d.sda_low = 1'b0;
                        // Direction bit
                        if (r_q.st == ics_pkg::ICS_D_AACK && r_q.shreg[0]) begin
                            r_d.st = ics_pkg::ICS_D_RD;
                            r_d.shreg = r_q.sel;
                            r_d.sda_low = ~r_q.sel[7];
                            r_d.bitn = 4'h1;
                        end else begin
                            r_d.st = ics_pkg::ICS_D_WR;
                        end
                    end
                end
                ics_pkg::ICS_D_RD: begin
                    if (scl_fall) begin
                        if (r_q.bitn == 4'h8) begin
                            r_d.sda_low = 1'b0;       // Release for master ack
                            r_d.st = ics_pkg::ICS_D_RACK;
                        end else begin
                            r_d.sda_low = ~r_q.shreg[3'h7 - r_q.bitn[2:0]];
                            r_d.bitn = r_q.bitn + 4'h1;
                        end
                    end
                end
                ics_pkg::ICS_D_RACK: begin
                    if (scl_rise) begin
                        // NACK leaves line released
                        if (r_q.sda_f) begin
                            r_d.st = ics_pkg::ICS_D_SKIP;
                        end else begin
                            // Master wants more: the select goes out again
                            r_d.st = ics_pkg::ICS_D_RD;
                        end
                        r_d.bitn = 4'h0;
                    end
                end
                ics_pkg::ICS_D_IDLE, ics_pkg::ICS_D_SKIP: begin
                    r_d.sda_low = 1'b0;
                end
                default: begin
                    r_d.st = ics_pkg::ICS_D_IDLE;
                end
            endcase
        end

        // Takes effect three cycles after the pin falls, far inside the release limit
        if (!r_q.rst_sy[1]) begin
            r_d.st = ics_pkg::ICS_D_IDLE;
            r_d.bitn = 4'h0;
            r_d.shreg = 8'h00;
            r_d.sel = `ICS_SEL_RESET;
            r_d.en = `ICS_SEL_RESET;
            r_d.sda_low = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        // Power-on stands in as sys_rst
        if (sys_rst) begin
            r_q <= '0;
            r_q.scl_sy <= 2'h3;
            r_q.sda_sy <= 2'h3;
            r_q.rst_sy <= 2'h3;
            r_q.scl_f <= 1'b1;
            r_q.sda_f <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // Open drain: only ever pulls low, the pull-up makes the high
    assign link.sda_dev_o = 1'b0;
    assign link.sda_dev_oe = r_q.sda_low;
    assign chan_en = r_q.en;
    assign sel_pending = r_q.sel;
endmodule

// [design/ics_host.sv]
// Upstream master: writes or reads the channel select over the link
`timescale 1ns/10ps
`include "ics_defs.svh"
module ics_host (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [1:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic [7:0]      rdata,
    ics_link_if.host        link
);
    typedef struct packed {
        ics_pkg::ics_host_state_t st;
        logic [7:0]               div;
        logic [4:0]               bitn;
        logic [2:0]               dev_addr;
        logic                     is_read;
        logic [7:0]               txb;
        logic [7:0]               rxb;
        logic [7:0]               result;
        logic                     nack;
        logic                     busy;
        logic                     scl;
        logic                     sda;
        logic [1:0]               sda_sy;
        logic [7:0]               rdata;
    } ics_host_reg_t;

    ics_host_reg_t r_q;
    ics_host_reg_t r_d;
    logic          tick;
    logic [4:0]    pos;
    logic [7:0]    abyte;

    always_comb begin
        r_d = r_q;
        r_d.sda_sy = {r_q.sda_sy[0], link.sda};
        tick = (r_q.div == `ICS_HALF_BIT);
        r_d.div = tick ? 8'h00 : r_q.div + 8'h01;
        pos = r_q.bitn;
        abyte = {`ICS_ADDR_UPPER, r_q.dev_addr, r_q.is_read};
        r_d.rdata = 8'h00;
        if (rd) begin
            case (addr)
                `ICS_REG_STATUS: r_d.rdata = {6'h00, r_q.nack, r_q.busy};
                `ICS_REG_RDATA:  r_d.rdata = r_q.result;
                `ICS_REG_WDATA:  r_d.rdata = r_q.txb;
                default:         r_d.rdata = {4'h0, r_q.dev_addr, r_q.is_read};
            endcase
        end
        if (wr && !r_q.busy) begin
            if (addr == `ICS_REG_WDATA) begin
                r_d.txb = wdata;
            end else if (addr == `ICS_REG_CTRL && wdata[`ICS_CMD_GO]) begin
                r_d.dev_addr = wdata[4:2];
                r_d.is_read = wdata[`ICS_CMD_READ];
                r_d.busy = 1'b1;
                r_d.nack = 1'b0;
                r_d.st = ics_pkg::ICS_H_IDLE;
            end
        end
        // Data moves mid-way through the low phase, never beside a clock edge
        if (r_q.st == ics_pkg::ICS_H_LOW && r_q.div == `ICS_QUARTER_BIT) begin
            if (pos < 5'h08) begin
                r_d.sda = abyte[3'h7 - pos[2:0]];
            end else if (pos == 5'h08) begin
                r_d.sda = 1'b1;                     // Release for ack
            end else if (pos == 5'h11) begin
                r_d.sda = 1'b1;                     // Release, or NACK on read
            end else begin
                r_d.sda = r_q.is_read ? 1'b1 : r_q.txb[3'h0 - pos[2:0]];
            end
        end
        if (tick) begin
            case (r_q.st)
                ics_pkg::ICS_H_IDLE: begin
                    // Start only from an idle bus
                    if (r_q.busy && r_q.sda_sy[1]) begin
                        r_d.sda = 1'b0;
                        r_d.st = ics_pkg::ICS_H_START;
                    end
                end
                ics_pkg::ICS_H_START: begin
                    r_d.scl = 1'b0;
                    r_d.bitn = 5'h00;
                    r_d.st = ics_pkg::ICS_H_LOW;
                end
                ics_pkg::ICS_H_LOW: begin
                    r_d.scl = 1'b1;
                    r_d.st = ics_pkg::ICS_H_HIGH;
                end
                ics_pkg::ICS_H_HIGH: begin
                    if (pos == 5'h08 && r_q.sda_sy[1]) begin
                        r_d.nack = 1'b1;
                    end
                    if (pos > 5'h08 && pos < 5'h11) begin
                        r_d.rxb = {r_q.rxb[6:0], r_q.sda_sy[1]};
                    end
                    r_d.scl = 1'b0;
                    r_d.bitn = r_q.bitn + 5'h01;
                    // Stop right after the control byte ack
                    if (pos == 5'h11 || (pos == 5'h08 && r_q.sda_sy[1])) begin
                        r_d.st = ics_pkg::ICS_H_STOP0;
                    end else begin
                        r_d.st = ics_pkg::ICS_H_LOW;
                    end
                end
                ics_pkg::ICS_H_STOP0: begin
                    r_d.sda = 1'b0;
                    r_d.st = ics_pkg::ICS_H_STOP1;
                end
                ics_pkg::ICS_H_STOP1: begin
                    r_d.scl = 1'b1;
                    r_d.st = ics_pkg::ICS_H_STOP2;
                end
                ics_pkg::ICS_H_STOP2: begin
                    r_d.sda = 1'b1;
                    r_d.st = ics_pkg::ICS_H_DONE;
                end
                ics_pkg::ICS_H_DONE: begin
                    r_d.result = r_q.rxb;
                    r_d.busy = 1'b0;
                    r_d.st = ics_pkg::ICS_H_IDLE;
                end
                default: begin
                    r_d.st = ics_pkg::ICS_H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r_q <= '0;
            r_q.scl <= 1'b1;
            r_q.sda <= 1'b1;
            r_q.sda_sy <= 2'h3;
        end else begin
            r_q <= r_d;
        end
    end

    assign link.scl_o = 1'b0;
    assign link.scl_oe = ~r_q.scl;
    assign link.sda_host_o = 1'b0;
    assign link.sda_host_oe = ~r_q.sda;
    assign rdata = r_q.rdata;
endmodule

// [testbench/ics_link_asserts.sv]
// Protocol checks on the link between host and switch device
`timescale 1ns/10ps
module ics_link_asserts (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       rst_in_n,
    input wire logic       scl,
    input wire logic       sda,
    input wire logic       sda_dev_oe,
    input wire logic [7:0] chan_en,
    input wire logic [7:0] sel_pending
);
    logic       sda_q;
    logic       in_txn_q;
    logic [4:0] since_q;
    logic       stop_det;
    logic       start_det;

    // Raw line edges; the device filters, so it reacts some cycles later
    assign stop_det  = scl & sda & ~sda_q;
    assign start_det = scl & ~sda & sda_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sda_q    <= 1'b1;
            in_txn_q <= 1'b0;
            since_q  <= 5'h1F;
        end else begin
            sda_q    <= sda;
            in_txn_q <= start_det | (in_txn_q & ~stop_det);
            if (stop_det | ~rst_in_n) begin
                since_q <= 5'h00;
            end else if (since_q != 5'h1F) begin
                since_q <= since_q + 5'h01;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_sel_por;
        $fell(sys_rst) |-> chan_en == 8'h00 && sel_pending == 8'h00 && !sda_dev_oe;
    endproperty
    a_sel_por: assert property (p_sel_por)
        else $error("state not cleared after power-on reset");

    property p_rst_clear;
        !rst_in_n [*3] |=> chan_en == 8'h00 && sel_pending == 8'h00;
    endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("reset pin did not clear selection");

    property p_rst_sda;
        $fell(rst_in_n) |-> ##[0:125] !sda_dev_oe;
    endproperty
    a_rst_sda: assert property (p_rst_sda)
        else $error("data line not released after reset pin");

    property p_chan_stop;
        !$stable(chan_en) |-> since_q < 5'h10;
    endproperty
    a_chan_stop: assert property (p_chan_stop)
        else $error("channel enables changed without stop");

    property p_chan_idle;
        (chan_en & ~$past(chan_en)) != 8'h00 |-> scl && sda;
    endproperty
    a_chan_idle: assert property (p_chan_idle)
        else $error("channel connected while lines not idle");

    property p_chan_follow;
        disable iff (sys_rst || !rst_in_n)
        stop_det |-> ##[1:16] chan_en == sel_pending;
    endproperty
    a_chan_follow: assert property (p_chan_follow)
        else $error("stop did not commit selection");

    property p_oe_scl_low;
        disable iff (sys_rst || !rst_in_n)
        !$stable(sda_dev_oe) |-> !scl;
    endproperty
    a_oe_scl_low: assert property (p_oe_scl_low)
        else $error("device data changed while clock high");

    property p_oe_txn;
        disable iff (sys_rst || !rst_in_n)
        sda_dev_oe |-> in_txn_q;
    endproperty
    a_oe_txn: assert property (p_oe_txn)
        else $error("device drove data outside a transaction");
endmodule

// [testbench/testbench.sv]
// Self-checking bench: host and switch device joined by the link
`timescale 1ns/10ps
`include "ics_defs.svh"
module testbench;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       rst_in_n = 1'b1;
    logic [2:0] addr_strap = 3'h0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] rdata;
    logic [7:0] chan_en;
    logic [7:0] sel_pending;
    logic [7:0] got;
    logic       split;
    int         failures = 0;
    int         num_checks = 0;
    int         cycles = 0;

    ics_link_if link ();
    ics_host u_ics_host (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .link(link));
    ics_device u_ics_device (.clk(clk), .sys_rst(sys_rst), .rst_in_n(rst_in_n),
        .addr_strap(addr_strap), .link(link), .chan_en(chan_en), .sel_pending(sel_pending));
    ics_link_asserts u_ics_link_asserts (.clk(clk), .sys_rst(sys_rst), .rst_in_n(rst_in_n),
        .scl(link.scl), .sda(link.sda), .sda_dev_oe(link.sda_dev_oe), .chan_en(chan_en),
        .sel_pending(sel_pending));

    always #2 clk = ~clk;

    // 15 transfers of under 3000 cycles each
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            failures++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] act, input logic [7:0] exp);
        num_checks++;
        if (act !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp);
        end
    endtask

    // Gap cycle after each strobe so no strobe is assigned twice in one step
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask

    // One host transfer; split flags a stored but not yet connected value
    task automatic xfer(input logic [2:0] ds, input logic [2:0] ha, input logic rd_op,
                        input logic [7:0] sel, output logic [7:0] st);
        logic [7:0] old;
        old = chan_en;
        addr_strap <= ds;
        reg_wr(`ICS_REG_WDATA, sel);
        reg_wr(`ICS_REG_CTRL, {3'h0, ha, rd_op, 1'b1});
        wait_done(sel, old, st);
    endtask

    // Polls busy; a transfer that never ends counts as a failure and ends the run
    task automatic wait_done(input logic [7:0] sel, input logic [7:0] old,
                             output logic [7:0] st);
        int n;
        n = 0;
        split = 1'b0;
        do begin
            reg_rd(`ICS_REG_STATUS, st);
            if (sel_pending === sel && chan_en === old && sel !== old) split = 1'b1;
            n++;
        end while (st[0] !== 1'b0 && n < 3000);
        if (st[0] !== 1'b0) begin
            failures++;
            complete_run();
        end
        repeat (16) @(posedge clk);
    endtask

    task automatic t_reset();
        check(chan_en, 8'h00);
        check(sel_pending, 8'h00);
    endtask

    task automatic t_addr_all();
        logic [7:0] st;
        for (int s = 0; s < 8; s++) begin
            xfer(3'(s), 3'(s), 1'b0, 8'h01 << s, st);
            check({7'h00, st[1]}, 8'h00);
            check(sel_pending, 8'h01 << s);
            check(chan_en, 8'h01 << s);
            check({7'h00, split}, 8'h01);
        end
    endtask

    task automatic t_read();
        logic [7:0] st;
        xfer(3'h6, 3'h6, 1'b0, 8'hA5, st);
        check(chan_en, 8'hA5);
        xfer(3'h6, 3'h6, 1'b1, 8'h00, st);
        check({7'h00, st[1]}, 8'h00);
        reg_rd(`ICS_REG_RDATA, got);
        check(got, 8'hA5);
        check(sel_pending, 8'hA5);
    endtask

    task automatic t_mismatch();
        logic [7:0] st;
        xfer(3'h3, 3'h5, 1'b0, 8'h3C, st);
        check({7'h00, st[1]}, 8'h01);
        check(sel_pending, 8'hA5);
        check(chan_en, 8'hA5);
    endtask

    task automatic t_rst_pin();
        logic [7:0] st;
        xfer(3'h2, 3'h2, 1'b0, 8'hFF, st);
        check(chan_en, 8'hFF);
        rst_in_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_in_n <= 1'b1;
        repeat (2) @(posedge clk);
        check(chan_en, 8'h00);
        check(sel_pending, 8'h00);
        xfer(3'h2, 3'h2, 1'b0, 8'h81, st);
        check(chan_en, 8'h81);
    endtask

    // Reset pin pulled while the device holds its address acknowledge
    task automatic t_rst_mid();
        logic [7:0] st;
        int         n;
        xfer(3'h4, 3'h4, 1'b0, 8'h5A, st);
        check(chan_en, 8'h5A);
        reg_wr(`ICS_REG_WDATA, 8'hC3);
        reg_wr(`ICS_REG_CTRL, {3'h0, 3'h4, 1'b0, 1'b1});
        n = 0;
        while (link.sda_dev_oe !== 1'b1 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        check({7'h00, link.sda_dev_oe}, 8'h01);
        rst_in_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_in_n <= 1'b1;
        @(posedge clk);
        check({7'h00, link.sda_dev_oe}, 8'h00);
        check(chan_en, 8'h00);
        wait_done(8'h00, 8'h00, st);
        check({7'h00, st[1]}, 8'h01);
        check(sel_pending, 8'h00);
        check(chan_en, 8'h00);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_addr_all();
        t_read();
        t_mismatch();
        t_rst_pin();
        t_rst_mid();
        complete_run();
    end
endmodule
